// ==== dv/event_partner.sv ====
/*
 * far-side model: companion timer ticks and event channel pulses.
 * assumes one clock shared with the timer; drives on the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module event_partner (
  input wire logic mclk,
  output logic companion_tick,
  output logic event_out
);
  // ************************************************************
  // idle levels
  // ************************************************************
  initial begin
    companion_tick = 1'b0;
    event_out = 1'b0;
  end
  // one-cycle companion ticks with idle gaps
  task automatic send_ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk) companion_tick = 1'b1;
      @(negedge mclk) companion_tick = 1'b0;
      repeat (2) @(negedge mclk);
    end
  endtask
  // event pulses held w cycles, w+1 low cycles between pulses, w after the last
  task automatic send_events(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk) event_out = 1'b1;
      repeat (w) @(negedge mclk);
      event_out = 1'b0;
      repeat (w) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/event_timer16_periodic_core_test.sv ====
/*
 * self-checking bench for the periodic timer core.
 * assumes the far-side model drives companion ticks and event pulses.
 */
`timescale 1ns/10ps
`default_nettype none
module event_timer16_periodic_core_test
  import event_timer16_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic mclk = 1'b0, rstn = 1'b0, enable = 1'b0, coe = 1'b0, nc = 1'b0;
  logic port_val = 1'b0, cclr = 1'b0, oclr = 1'b0, tick, evt;
  logic [2:0] sel = SOURCE_DIV1;
  logic [15:0] cmp = 16'h0000, count, base;
  logic capf, ovff, cape, ovfe, bot, mx, pin, w0;
  timer_mode_e mode = MODE_PERIODIC, mact;
  int fails = 0, comparisons = 0;
  always #5 mclk = ~mclk;
  event_timer16_periodic_core #(.WIDTH(16), .FILTER_LEN(4)) event_timer16_periodic_core_i (
    .MCLK(mclk), .RSTN(rstn), .ENABLE(enable), .CLOCK_SOURCE_SELECT(sel), .MODE(mode),
    .COMPARE_OUTPUT_ENABLE(coe), .NOISE_CANCEL_EN(nc), .COMPARE_CAPTURE_VALUE(cmp),
    .COMPANION_TIMER_TICK(tick), .EVENT_IN(evt), .PORT_OUT_VALUE(port_val),
    .CAPTURE_FLAG_CLR(cclr), .OVERFLOW_FLAG_CLR(oclr), .COUNT_VALUE(count),
    .CAPTURE_FLAG(capf), .OVERFLOW_FLAG(ovff), .CAPTURE_EVENT(cape),
    .OVERFLOW_EVENT(ovfe), .AT_BOTTOM(bot), .AT_MAX(mx), .PIN_OUT(pin), .MODE_ACTIVE(mact));
  event_partner event_partner_i (.mclk(mclk), .companion_tick(tick), .event_out(evt));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // runs one source for a span and returns the count advance
  task automatic run_src(input logic [2:0] s, input int cyc, output logic [15:0] d);
    @(negedge mclk) base = count;
    sel = s;
    enable = 1'b1;
    repeat (cyc) @(negedge mclk);
    enable = 1'b0;
    d = count - base;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_periodic();
    @(negedge mclk) cmp = 16'h0003;
    coe = 1'b1;
    enable = 1'b1;
    w0 = 1'b0; // waveform idles low after reset
    for (int i = 1; i <= 4; i++) begin
      @(negedge mclk);
      check(count, 16'(i % 4));
      check(cape, i == 4);
    end
    check(pin, !w0);
    enable = 1'b0;
    @(negedge mclk) check(cape, 1'b0);
    check(capf, 1'b1);
    cclr = 1'b1;
    @(negedge mclk) cclr = 1'b0;
    check(capf, 1'b0);
  endtask
  task automatic t_wrap();
    int n;
    @(negedge mclk) cmp = 16'h0010;
    enable = 1'b1;
    repeat (8) @(negedge mclk);
    cmp = 16'h0004;
    n = 0;
    while (mx !== 1'b1 && n < 70000) begin
      @(negedge mclk) n++;
    end
    check(count, COUNT_MAX);
    check(capf, 1'b0);
    @(negedge mclk) enable = 1'b0;
    check(count, COUNT_BOTTOM);
    check(bot, 1'b1);
    check(ovfe, 1'b1);
    check(ovff, 1'b1);
    @(negedge mclk) check(ovfe, 1'b0);
    oclr = 1'b1;
    @(negedge mclk) oclr = 1'b0;
    check(ovff, 1'b0);
  endtask
  task automatic t_sources();
    logic [15:0] d;
    cmp = 16'hFFF0;
    run_src(SOURCE_DIV2, 10, d);
    check(d, 16'h0005);
    fork
      run_src(SOURCE_COMPANION, 24, d);
      event_partner_i.send_ticks(5);
    join
    check(d, 16'h0005);
    for (int k = 0; k < 2; k++) begin
      nc = k[0];
      fork
        run_src(SOURCE_EVENT, 64, d);
        event_partner_i.send_events(3, 8);
      join
      check(d, 16'h0003);
    end
  endtask
  task automatic t_pin_modes();
    @(negedge mclk) coe = 1'b0;
    for (int v = 0; v < 2; v++) begin
      @(negedge mclk) port_val = v[0];
      #1 check(pin, v[0]);
    end
    @(negedge mclk) coe = 1'b1;
    #1 w0 = pin;
    @(negedge mclk) port_val = 1'b0;
    #1 check(pin, w0);
    for (int m = 0; m < 8; m++) begin
      @(negedge mclk) mode = timer_mode_e'(m);
      #1 check(16'(mact), 16'(m));
    end
    // outside periodic mode the count runs past the compare value
    @(negedge mclk) mode = MODE_TIMEOUT;
    sel = SOURCE_DIV1;
    base = count;
    cmp = count + 16'h0002;
    enable = 1'b1;
    repeat (4) @(negedge mclk);
    enable = 1'b0;
    check(count - base, 16'h0004);
    check(capf, 1'b0);
    @(negedge mclk) mode = MODE_PERIODIC;
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    check(count, COUNT_BOTTOM);
    check(16'(mact), 16'(MODE_PERIODIC));
    check({capf, ovff}, 2'b00);
    t_periodic();
    t_wrap();
    t_sources();
    t_pin_modes();
    finish_test();
  end
  initial begin
    #(90000 * 10);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire

// ==== rtl/event_timer16_periodic_core.sv ====
/*
 * 16-bit event timer base: clock source selection, count limits and
 * periodic mode with capture/overflow flags, events and waveform output.
 * assumes control bits driven by same-clock logic; event input is from
 * outside and is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - counter clocked by peripheral, companion, or event
// - clock select picks prescaler output or event
// - companion clock selected advances with companion timer
// - bottom recognised at count zero
// - maximum recognised at count all ones
// - top is compare value in periodic mode
// - counter is sixteen bits wide
// - eight selectable operating modes exist
// - periodic mode after reset; MODE is an input here, which RSTN does not load
// - output enable drives pin over port value
// - enable starts counting at selected rate
// - count value readable at any time
// - top sets capture flag and capture event
// - compare below count wraps through maximum
// - maximum sets overflow flag and event
// - optional noise canceller before edge detection
// - periodic mode restarts from zero after top
module event_timer16_periodic_core
  import event_timer16_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int FILTER_LEN = 4
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic ENABLE,
  input wire logic [2:0] CLOCK_SOURCE_SELECT,
  input wire timer_mode_e MODE,
  input wire logic COMPARE_OUTPUT_ENABLE,
  input wire logic NOISE_CANCEL_EN,
  input wire logic [WIDTH-1:0] COMPARE_CAPTURE_VALUE,
  input wire logic COMPANION_TIMER_TICK,
  input wire logic EVENT_IN,
  input wire logic PORT_OUT_VALUE,
  input wire logic CAPTURE_FLAG_CLR,
  input wire logic OVERFLOW_FLAG_CLR,
  output logic [WIDTH-1:0] COUNT_VALUE,
  output logic CAPTURE_FLAG,
  output logic OVERFLOW_FLAG,
  output logic CAPTURE_EVENT,
  output logic OVERFLOW_EVENT,
  output logic AT_BOTTOM,
  output logic AT_MAX,
  output logic PIN_OUT,
  output var timer_mode_e MODE_ACTIVE
);
  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (WIDTH != 16) begin : g_width_chk
    $error("counter width must be 16");
  end
  if (FILTER_LEN < 2 || FILTER_LEN > 8) begin : g_filt_chk
    $error("filter length must be 2..8");
  end

  // ************************************************************
  // event input synchroniser and noise canceller
  // ************************************************************
  logic ev_meta_r; // first stage, read only by second
  logic ev_sync_r; // synchronised event level
  logic [FILTER_LEN-1:0] ev_hist_r; // filter history
  logic ev_filt_r; // filtered level
  logic ev_prev_r; // level for edge detection
  logic ev_level; // level fed to edge detector
  logic ev_rise; // rising edge tick

  // two-flop synchroniser
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_meta_r <= 1'b0;
      ev_sync_r <= 1'b0;
    end else begin
      ev_meta_r <= EVENT_IN;
      ev_sync_r <= ev_meta_r;
    end
  end

  // filter: output follows only a stable run of samples
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_hist_r <= '0;
      ev_filt_r <= 1'b0;
    end else begin
      ev_hist_r <= {ev_hist_r[FILTER_LEN-2:0], ev_sync_r};
      if (&ev_hist_r) begin
        ev_filt_r <= 1'b1;
      end else if (~|ev_hist_r) begin
        ev_filt_r <= 1'b0;
      end
    end
  end

  assign ev_level = NOISE_CANCEL_EN ? ev_filt_r : ev_sync_r;

  // edge detector state
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_prev_r <= 1'b0;
    end else begin
      ev_prev_r <= ev_level;
    end
  end

  // with the noise canceller on, a pulse held under FILTER_LEN cycles is missed
  assign ev_rise = ev_level & ~ev_prev_r;

  // ************************************************************
  // prescaler and clock source selection
  // ************************************************************
  logic div2_r; // divide-by-two toggle
  logic tick; // effective counter clock enable

  // divide-by-two enable generator
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      div2_r <= 1'b0;
    end else begin
      div2_r <= ~div2_r;
    end
  end

  // choose the effective tick
  always_comb begin
    unique case (CLOCK_SOURCE_SELECT)
      SOURCE_DIV1: tick = 1'b1;
      SOURCE_DIV2: tick = div2_r;
      SOURCE_COMPANION: tick = COMPANION_TIMER_TICK;
      SOURCE_EVENT: tick = ev_rise;
      default: tick = 1'b0;
    endcase
  end

  // ************************************************************
  // counter
  // ************************************************************
  logic [WIDTH-1:0] count_r; // count register
  logic run; // counting this cycle
  logic hit_top; // top reached on this tick
  logic hit_max; // maximum reached on this tick

  assign run = ENABLE & tick;
  assign hit_top = run && (MODE == MODE_PERIODIC) && (count_r == COMPARE_CAPTURE_VALUE);
  assign hit_max = run && (count_r == COUNT_MAX);

  // count up, restart at top, wrap through max
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      count_r <= COUNT_BOTTOM;
    end else if (run) begin
      if (hit_top || hit_max) begin
        count_r <= COUNT_BOTTOM;
      end else begin
        count_r <= count_r + COUNT_ONE;
      end
    end
  end

  assign COUNT_VALUE = count_r;
  assign AT_BOTTOM = (count_r == COUNT_BOTTOM);
  assign AT_MAX = (count_r == COUNT_MAX);
  assign MODE_ACTIVE = MODE;

  // ************************************************************
  // flags and events
  // ************************************************************
  logic capture_flag_r; // sticky capture flag
  logic overflow_flag_r; // sticky overflow flag
  logic capture_ev_r; // capture event pulse
  logic overflow_ev_r; // overflow event pulse

  // sticky flags, set wins over clear
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      capture_flag_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end else begin
      if (hit_top) begin
        capture_flag_r <= 1'b1;
      end else if (CAPTURE_FLAG_CLR) begin
        capture_flag_r <= 1'b0;
      end
      if (hit_max) begin
        overflow_flag_r <= 1'b1;
      end else if (OVERFLOW_FLAG_CLR) begin
        overflow_flag_r <= 1'b0;
      end
    end
  end

  // single-cycle event pulses
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      capture_ev_r <= 1'b0;
      overflow_ev_r <= 1'b0;
    end else begin
      capture_ev_r <= hit_top;
      overflow_ev_r <= hit_max;
    end
  end

  assign CAPTURE_FLAG = capture_flag_r;
  assign OVERFLOW_FLAG = overflow_flag_r;
  assign CAPTURE_EVENT = capture_ev_r;
  assign OVERFLOW_EVENT = overflow_ev_r;

  // ************************************************************
  // waveform output
  // ************************************************************
  logic wave_r; // waveform toggles at each top

  // toggle waveform on capture
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wave_r <= 1'b0;
    end else if (hit_top) begin
      wave_r <= ~wave_r;
    end
  end

  assign PIN_OUT = COMPARE_OUTPUT_ENABLE ? wave_r : PORT_OUT_VALUE;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_capture_event;
    @(posedge MCLK) disable iff (!RSTN)
      hit_top |=> (CAPTURE_EVENT && CAPTURE_FLAG);
  endproperty
  a_capture_event: assert property (p_capture_event) else $error("capture not raised at top");

  property p_overflow_event;
    @(posedge MCLK) disable iff (!RSTN)
      (run && count_r == COUNT_MAX) |=> (OVERFLOW_EVENT && OVERFLOW_FLAG && count_r == COUNT_BOTTOM);
  endproperty
  a_overflow_event: assert property (p_overflow_event) else $error("overflow not raised at max");

  // an event pulse only ever follows its own condition
  property p_capture_origin;
    @(posedge MCLK) disable iff (!RSTN)
      CAPTURE_EVENT |-> $past(hit_top);
  endproperty
  a_capture_origin: assert property (p_capture_origin) else $error("stray capture event");

  property p_overflow_origin;
    @(posedge MCLK) disable iff (!RSTN)
      OVERFLOW_EVENT |-> $past(hit_max);
  endproperty
  a_overflow_origin: assert property (p_overflow_origin) else $error("stray overflow event");

  // waveform must flip once per top
  property p_wave_toggle;
    @(posedge MCLK) disable iff (!RSTN)
      hit_top |=> (wave_r != $past(wave_r));
  endproperty
  a_wave_toggle: assert property (p_wave_toggle) else $error("waveform did not toggle at top");

  property p_restart;
    @(posedge MCLK) disable iff (!RSTN)
      hit_top |=> (COUNT_VALUE == COUNT_BOTTOM);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after top");

  property p_pulse;
    @(posedge MCLK) disable iff (!RSTN)
      CAPTURE_EVENT |=> !CAPTURE_EVENT || $past(hit_top);
  endproperty
  a_pulse: assert property (p_pulse) else $error("capture event not a pulse");

  property p_sticky;
    @(posedge MCLK) disable iff (!RSTN)
      (CAPTURE_FLAG && !CAPTURE_FLAG_CLR) |=> CAPTURE_FLAG;
  endproperty
  a_sticky: assert property (p_sticky) else $error("capture flag dropped");

  property p_hold;
    @(posedge MCLK) disable iff (!RSTN)
      !ENABLE |=> $stable(COUNT_VALUE);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  property p_step;
    @(posedge MCLK) disable iff (!RSTN)
      (run && !hit_top && !hit_max) |=> (COUNT_VALUE == $past(COUNT_VALUE) + COUNT_ONE);
  endproperty
  a_step: assert property (p_step) else $error("count did not advance");

  property p_pin;
    @(posedge MCLK) disable iff (!RSTN)
      COMPARE_OUTPUT_ENABLE |-> (PIN_OUT == wave_r);
  endproperty
  a_pin: assert property (p_pin) else $error("waveform not on pin");

  property p_bottom;
    @(posedge MCLK) disable iff (!RSTN)
      hit_top |=> AT_BOTTOM;
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom not flagged");
endmodule
`default_nettype wire

// ==== rtl/event_timer16_pkg.sv ====
/*
 * constants, source encodings and mode enumeration for the 16-bit event timer.
 * assumes nothing of its surroundings; included before the timer module.
 */
package event_timer16_pkg;
  // ************************************************************
  // count limits
  // ************************************************************
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000; // bottom value
  localparam logic [15:0] COUNT_MAX = 16'hFFFF; // maximum value
  localparam logic [15:0] COUNT_ONE = 16'h0001; // increment step
  localparam logic [15:0] COMPARE_RESET = 16'h0000; // compare reset value
  // ************************************************************
  // clock source select encodings
  // ************************************************************
  localparam logic [2:0] SOURCE_DIV1 = 3'h0; // peripheral clock
  localparam logic [2:0] SOURCE_DIV2 = 3'h1; // peripheral clock / 2
  localparam logic [2:0] SOURCE_COMPANION = 3'h2; // companion timer clock
  localparam logic [2:0] SOURCE_EVENT = 3'h7; // event channel
  localparam logic [2:0] SOURCE_RESET = 3'h0; // select reset value
  // ************************************************************
  // operating modes; periodic first so it takes encoding 3'h0
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_PERIODIC,
    MODE_TIMEOUT,
    MODE_CAPTURE_EVENT,
    MODE_CAPTURE_FREQ,
    MODE_CAPTURE_PW,
    MODE_CAPTURE_FREQ_PW,
    MODE_SINGLE,
    MODE_PWM8
  } timer_mode_e;
endpackage
